// *** hw/t2io_regs.sv ***
// io-space decoder with timer-two registers and a bit-accessible flag register
//
// Behaviour
// - bit set/clear only for io 0x00-0x1F
// - skip ops test one bit, low range
// - flags clear on one, zero leaves them
// - bit set/clear touches only addressed bit
// - in/out reach only io 0x00-0x3F
// - data-space address is io address plus 0x20
// - extended 0x60-0xFF only by load/store
`include "t2io_cfg.svh"

module t2io_regs (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_resetn,
  // core access
  input wire t2io_pkg::t2io_op_e i_op,
  input wire logic [7:0] i_addr,
  input wire logic [2:0] i_bit,
  input wire logic [7:0] i_wdata,
  // core answer
  output logic o_ack,
  output logic [7:0] o_rdata,
  output logic o_skip,
  output logic o_err,
  // timer side
  input wire logic i_count_step,
  input wire logic [2:0] i_flag_set,
  output logic [7:0] o_ctrl_a,
  output logic [7:0] o_ctrl_b,
  output logic [7:0] o_count,
  output logic [7:0] o_cmp_a,
  output logic [7:0] o_cmp_b,
  output logic o_force_a,
  output logic o_force_b,
  output logic [7:0] o_flags
);

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic is_short;
  logic is_bit;
  logic is_test;
  logic is_ds;
  logic bad;
  logic [7:0] daddr;
  logic do_write;
  logic do_bitwr;
  logic do_read;
  logic sel_ctrl_a;
  logic sel_ctrl_b;
  logic sel_count;
  logic sel_cmp_a;
  logic sel_cmp_b;
  logic sel_flag;
  logic [7:0] rd_val;
  logic [7:0] bit_value;
  logic bit_now;

  assign is_short = (i_op == t2io_pkg::T2IO_OP_IN) || (i_op == t2io_pkg::T2IO_OP_OUT);
  assign is_bit = (i_op == t2io_pkg::T2IO_OP_BIT_SET) || (i_op == t2io_pkg::T2IO_OP_BIT_CLEAR);
  assign is_test = (i_op == t2io_pkg::T2IO_OP_SKIP_SET) || (i_op == t2io_pkg::T2IO_OP_SKIP_CLEAR);
  assign is_ds = (i_op == t2io_pkg::T2IO_OP_LOAD) || (i_op == t2io_pkg::T2IO_OP_STORE);

  always_comb begin
    if ((is_bit || is_test) && (i_addr > `T2IO_BIT_IO_MAX)) begin
      bad = 1'b1;
    end else if (is_short && (i_addr > `T2IO_PORT_IO_MAX)) begin
      bad = 1'b1;
    end else begin
      bad = 1'b0;
    end
  end

  // short forms above 0x3f are refused, so a sum of 0x60 and up is never acted on
  assign daddr = is_ds ? i_addr : 8'(i_addr + `T2IO_IO_OFFSET);

  assign do_write = !bad && ((i_op == t2io_pkg::T2IO_OP_OUT) || (i_op == t2io_pkg::T2IO_OP_STORE));
  assign do_bitwr = !bad && is_bit;
  assign do_read = !bad && ((i_op == t2io_pkg::T2IO_OP_IN) || (i_op == t2io_pkg::T2IO_OP_LOAD));

  always_comb begin
    sel_ctrl_a = 1'b0;
    sel_ctrl_b = 1'b0;
    sel_count = 1'b0;
    sel_cmp_a = 1'b0;
    sel_cmp_b = 1'b0;
    sel_flag = 1'b0;
    if (daddr == `T2IO_CTRL_A_ADDR) begin
      sel_ctrl_a = 1'b1;
    end else if (daddr == `T2IO_CTRL_B_ADDR) begin
      sel_ctrl_b = 1'b1;
    end else if (daddr == `T2IO_COUNT_ADDR) begin
      sel_count = 1'b1;
    end else if (daddr == `T2IO_CMP_A_ADDR) begin
      sel_cmp_a = 1'b1;
    end else if (daddr == `T2IO_CMP_B_ADDR) begin
      sel_cmp_b = 1'b1;
    end else if (daddr == 8'(`T2IO_FLAG_IO_ADDR + `T2IO_IO_OFFSET)) begin
      sel_flag = 1'b1;
    end
  end

  // reserved addresses fall through to zero
  always_comb begin
    if (sel_ctrl_a) begin
      rd_val = o_ctrl_a;
    end else if (sel_ctrl_b) begin
      rd_val = o_ctrl_b;
    end else if (sel_count) begin
      rd_val = o_count;
    end else if (sel_cmp_a) begin
      rd_val = o_cmp_a;
    end else if (sel_cmp_b) begin
      rd_val = o_cmp_b;
    end else if (sel_flag) begin
      rd_val = o_flags;
    end else begin
      rd_val = 8'h00;
    end
  end

  // only the flag register lives in the bit-accessible range here
  t2io_bitop #(
    .WIDTH(8)
  ) u_bitop (
    .i_value(o_flags),
    .i_w1c_mask(`T2IO_FLAG_MASK),
    .i_bit(i_bit),
    .i_set(i_op == t2io_pkg::T2IO_OP_BIT_SET),
    .o_write_value(bit_value),
    .o_bit(bit_now)
  );

  // ----------------------------------------------------------------
  // answer
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_ack <= 1'b0;
      o_rdata <= 8'h00;
      o_skip <= 1'b0;
      o_err <= 1'b0;
    end else begin
      o_ack <= (i_op != t2io_pkg::T2IO_OP_NONE);
      o_err <= bad;
      o_rdata <= do_read ? rd_val : 8'h00;
      if (!bad && is_test && sel_flag) begin
        o_skip <= (i_op == t2io_pkg::T2IO_OP_SKIP_SET) ? bit_now : !bit_now;
      end else begin
        o_skip <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // timer-two registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_ctrl_a <= `T2IO_CTRL_A_RST;
      o_ctrl_b <= `T2IO_CTRL_B_RST;
      o_cmp_a <= `T2IO_CMP_A_RST;
      o_cmp_b <= `T2IO_CMP_B_RST;
    end else if (do_write) begin
      if (sel_ctrl_a) begin
        o_ctrl_a <= i_wdata & `T2IO_CTRL_A_MASK;
      end
      if (sel_ctrl_b) begin
        o_ctrl_b <= i_wdata & `T2IO_CTRL_B_MASK;
      end
      if (sel_cmp_a) begin
        o_cmp_a <= i_wdata;
      end
      if (sel_cmp_b) begin
        o_cmp_b <= i_wdata;
      end
    end
  end

  // force bits are strobes: they act once and always read back as zero
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_force_a <= 1'b0;
      o_force_b <= 1'b0;
    end else begin
      o_force_a <= do_write && sel_ctrl_b && i_wdata[`T2IO_FORCE_A_BIT];
      o_force_b <= do_write && sel_ctrl_b && i_wdata[`T2IO_FORCE_B_BIT];
    end
  end

  // a software write beats a same-cycle step from the timer
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_count <= `T2IO_COUNT_RST;
    end else if (do_write && sel_count) begin
      o_count <= i_wdata;
    end else if (i_count_step) begin
      o_count <= 8'(o_count + 8'h01);
    end
  end

  // ----------------------------------------------------------------
  // write-one-to-clear flags
  // ----------------------------------------------------------------
  logic [7:0] flag_clr;

  always_comb begin
    if (do_write && sel_flag) begin
      flag_clr = i_wdata & `T2IO_FLAG_MASK;
    end else if (do_bitwr && sel_flag) begin
      flag_clr = bit_value & `T2IO_FLAG_MASK;
    end else begin
      flag_clr = 8'h00;
    end
  end

  // a set in the clearing cycle wins
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_flags <= `T2IO_FLAG_RST;
    end else begin
      o_flags <= (o_flags & ~flag_clr) | {5'b00000, i_flag_set};
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_resetn);

  sequence s_flag_bit_set_req;
    (i_op == t2io_pkg::T2IO_OP_BIT_SET) && (i_addr == `T2IO_FLAG_IO_ADDR);
  endsequence

  property p_bit_range;
    (is_bit || is_test) && (i_addr > `T2IO_BIT_IO_MAX) |=> o_ack && o_err && !o_skip;
  endproperty
  a_bit_range: assert property (p_bit_range) else $error("bit op above 0x1f not refused");

  property p_skip_value;
    (i_op == t2io_pkg::T2IO_OP_SKIP_SET) && (i_addr == `T2IO_FLAG_IO_ADDR) |=> o_skip == $past(o_flags[i_bit]);
  endproperty
  a_skip_value: assert property (p_skip_value) else $error("skip result differs from tested bit");

  property p_zero_write_keeps;
    (i_op == t2io_pkg::T2IO_OP_STORE) && (daddr == 8'h37) && (i_wdata == 8'h00) |=> (o_flags & $past(o_flags)) == $past(o_flags);
  endproperty
  a_zero_write_keeps: assert property (p_zero_write_keeps) else $error("zero write changed a flag");

  property p_bit_only_addressed;
    s_flag_bit_set_req ##0 (i_flag_set == 3'b000) |=> ((o_flags ^ $past(o_flags)) & ~(8'h01 << $past(i_bit))) == 8'h00;
  endproperty
  a_bit_only_addressed: assert property (p_bit_only_addressed) else $error("bit set disturbed another flag");

  property p_port_range;
    is_short && (i_addr > `T2IO_PORT_IO_MAX) |=> o_ack && o_err && (o_rdata == 8'h00);
  endproperty
  a_port_range: assert property (p_port_range) else $error("port op above 0x3f not refused");

  property p_offset_read;
    (i_op == t2io_pkg::T2IO_OP_IN) && (i_addr == `T2IO_FLAG_IO_ADDR) && (i_flag_set == 3'b000) |=> o_rdata == o_flags;
  endproperty
  a_offset_read: assert property (p_offset_read) else $error("io read not mapped at plus 0x20");

  property p_ext_unreachable;
    (i_op == t2io_pkg::T2IO_OP_OUT) |=> $stable(o_cmp_a) && $stable(o_cmp_b) && $stable(o_ctrl_a);
  endproperty
  a_ext_unreachable: assert property (p_ext_unreachable) else $error("port write reached extended range");

  property p_reserved_zero;
    (i_op == t2io_pkg::T2IO_OP_LOAD) && (i_addr == 8'hb5) |=> o_ack && (o_rdata == 8'h00);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved address read not zero");

  property p_cmp_store;
    (i_op == t2io_pkg::T2IO_OP_STORE) && (i_addr == `T2IO_CMP_A_ADDR) |=> o_ack && (o_cmp_a == $past(i_wdata));
  endproperty
  a_cmp_store: assert property (p_cmp_store) else $error("compare store not taken");

endmodule : t2io_regs

// *** inc/t2io_cfg.svh ***
// address map, field masks, reset values for the timer-two register window
`ifndef T2IO_CFG_SVH
`define T2IO_CFG_SVH

// ----------------------------------------------------------------
// address ranges
// ----------------------------------------------------------------
`define T2IO_BIT_IO_MAX 8'h1f
`define T2IO_PORT_IO_MAX 8'h3f
`define T2IO_IO_OFFSET 8'h20
`define T2IO_EXT_LO 8'h60

// ----------------------------------------------------------------
// register addresses: data space, flag register as io address
// ----------------------------------------------------------------
`define T2IO_CTRL_A_ADDR 8'hb0
`define T2IO_CTRL_B_ADDR 8'hb1
`define T2IO_COUNT_ADDR 8'hb2
`define T2IO_CMP_A_ADDR 8'hb3
`define T2IO_CMP_B_ADDR 8'hb4
`define T2IO_FLAG_IO_ADDR 8'h17

// ----------------------------------------------------------------
// field masks
// ----------------------------------------------------------------
`define T2IO_CTRL_A_MASK 8'hf3
`define T2IO_CTRL_B_MASK 8'h0f
`define T2IO_FORCE_A_BIT 7
`define T2IO_FORCE_B_BIT 6
`define T2IO_FLAG_MASK 8'h07

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define T2IO_CTRL_A_RST 8'h00
`define T2IO_CTRL_B_RST 8'h00
`define T2IO_COUNT_RST 8'h00
`define T2IO_CMP_A_RST 8'h00
`define T2IO_CMP_B_RST 8'h00
`define T2IO_FLAG_RST 8'h00

`endif

// *** inc/t2io_pkg.sv ***
// types shared by the timer-two register window
package t2io_pkg;

  typedef enum logic [3:0] {
    T2IO_OP_NONE = 4'b0000,
    T2IO_OP_IN = 4'b0001,
    T2IO_OP_OUT = 4'b0010,
    T2IO_OP_LOAD = 4'b0011,
    T2IO_OP_STORE = 4'b0100,
    T2IO_OP_BIT_SET = 4'b0101,
    T2IO_OP_BIT_CLEAR = 4'b0110,
    T2IO_OP_SKIP_SET = 4'b0111,
    T2IO_OP_SKIP_CLEAR = 4'b1000
  } t2io_op_e;

endpackage : t2io_pkg

// *** hw/t2io_bitop.sv ***
// per-bit value builder for single-bit set and clear on a register
module t2io_bitop #(
  parameter int WIDTH = 8
) (
  // register state
  input wire logic [WIDTH-1:0] i_value,
  input wire logic [WIDTH-1:0] i_w1c_mask,
  // operation
  input wire logic [2:0] i_bit,
  input wire logic i_set,
  // result
  output logic [WIDTH-1:0] o_write_value,
  output logic o_bit
);

  // w1c bits get a one only at the addressed position, so siblings are
  // never cleared by the read-modify-write
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_comb begin
        if (i_bit == 3'(g)) begin
          o_write_value[g] = i_set;
        end else if (i_w1c_mask[g]) begin
          o_write_value[g] = 1'b0;
        end else begin
          o_write_value[g] = i_value[g];
        end
      end
    end
  endgenerate

  assign o_bit = i_value[i_bit];

endmodule : t2io_bitop

// *** testbench/t2io_core_model.sv ***
// processor core model driving io and data-space requests
module t2io_core_model (
  // request
  output t2io_pkg::t2io_op_e o_op,
  output logic [7:0] o_addr,
  output logic [2:0] o_bit,
  output logic [7:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // request driver
  // ----------------------------------------------------------------
  // raw lets a scenario break the software habits on purpose
  logic raw = 1'b0;
  initial begin
    o_op = t2io_pkg::T2IO_OP_NONE;
    o_addr = 8'h0;
    o_bit = 3'h0;
    o_wdata = 8'h0;
  end
  // call just after a falling edge; request holds until the next call
  task automatic req(input t2io_pkg::t2io_op_e op, input logic [7:0] a, input logic [2:0] b,
                     input logic [7:0] d);
    logic drop;
    logic [7:0] m;
    drop = !raw && (op inside {t2io_pkg::T2IO_OP_STORE, t2io_pkg::T2IO_OP_OUT}) &&
           !(a inside {8'h17, 8'h37, [8'hb0:8'hb4]});
    m = (a == 8'hb0) ? 8'hf3 : (a == 8'hb1) ? 8'hcf : 8'hff;
    o_op = drop ? t2io_pkg::T2IO_OP_NONE : op;
    o_addr = a;
    o_bit = b;
    o_wdata = raw ? d : (d & m);
  endtask : req
endmodule : t2io_core_model

// *** testbench/tb.sv ***
// self-checking bench for the timer-two register window
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam t2io_pkg::t2io_op_e NOP = t2io_pkg::T2IO_OP_NONE;
  localparam t2io_pkg::t2io_op_e IN = t2io_pkg::T2IO_OP_IN;
  localparam t2io_pkg::t2io_op_e OUT = t2io_pkg::T2IO_OP_OUT;
  localparam t2io_pkg::t2io_op_e LD = t2io_pkg::T2IO_OP_LOAD;
  localparam t2io_pkg::t2io_op_e ST = t2io_pkg::T2IO_OP_STORE;
  localparam t2io_pkg::t2io_op_e BS = t2io_pkg::T2IO_OP_BIT_SET;
  localparam t2io_pkg::t2io_op_e BC = t2io_pkg::T2IO_OP_BIT_CLEAR;
  localparam t2io_pkg::t2io_op_e KS = t2io_pkg::T2IO_OP_SKIP_SET;
  localparam t2io_pkg::t2io_op_e KC = t2io_pkg::T2IO_OP_SKIP_CLEAR;
  // v is write data for writes, expected read data for reads; se is {err, skip}
  typedef struct {
    t2io_pkg::t2io_op_e op;
    logic [7:0] a;
    logic [2:0] b;
    logic [7:0] v;
    logic [1:0] se;
  } t2io_row_s;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic step = 1'b0;
  logic [2:0] fset = 3'h0;
  t2io_pkg::t2io_op_e op;
  logic [7:0] addr, wdata, rdata, ca, cb, cnt, ma, mb, flags;
  logic [2:0] bitn;
  logic ack, skip, err, fa, fb;
  int n_mismatch = 0;
  int cmp_count = 0;
  wire logic [60:0] all_out = {ack, rdata, skip, err, ca, cb, cnt, ma, mb, fa, fb, flags};
  t2io_row_s rows [36] = '{
    '{ST, 8'hb3, 3'h0, 8'h5a, 2'h0}, '{ST, 8'hb4, 3'h0, 8'ha5, 2'h0}, '{LD, 8'hb3, 3'h0, 8'h5a, 2'h0},
    '{LD, 8'hb4, 3'h0, 8'ha5, 2'h0}, '{ST, 8'hb0, 3'h0, 8'hff, 2'h0}, '{LD, 8'hb0, 3'h0, 8'hf3, 2'h0},
    '{ST, 8'hb1, 3'h0, 8'h3f, 2'h0}, '{LD, 8'hb1, 3'h0, 8'h0f, 2'h0}, '{ST, 8'hb2, 3'h0, 8'h33, 2'h0},
    '{LD, 8'hb2, 3'h0, 8'h33, 2'h0}, '{ST, 8'hb5, 3'h0, 8'hff, 2'h0}, '{LD, 8'hb5, 3'h0, 8'h0, 2'h0},
    '{IN, 8'h17, 3'h0, 8'h07, 2'h0}, '{LD, 8'h37, 3'h0, 8'h07, 2'h0}, '{ST, 8'h37, 3'h0, 8'h00, 2'h0},
    '{KS, 8'h17, 3'h1, 8'h0, 2'h1},
    '{KC, 8'h17, 3'h1, 8'h0, 2'h0}, '{BC, 8'h17, 3'h0, 8'h0, 2'h0}, '{BS, 8'h17, 3'h1, 8'h0, 2'h0},
    '{IN, 8'h17, 3'h0, 8'h05, 2'h0}, '{KC, 8'h17, 3'h1, 8'h0, 2'h1}, '{KS, 8'h17, 3'h3, 8'h0, 2'h0},
    '{ST, 8'h37, 3'h0, 8'h04, 2'h0}, '{IN, 8'h17, 3'h0, 8'h01, 2'h0}, '{OUT, 8'h17, 3'h0, 8'h01, 2'h0},
    '{LD, 8'h37, 3'h0, 8'h0, 2'h0}, '{IN, 8'h3f, 3'h0, 8'h0, 2'h0}, '{IN, 8'h40, 3'h0, 8'h0, 2'h2},
    '{OUT, 8'h40, 3'h0, 8'h01, 2'h2}, '{IN, 8'h90, 3'h0, 8'h0, 2'h2}, '{BS, 8'h1f, 3'h0, 8'h0, 2'h0},
    '{BS, 8'h20, 3'h0, 8'h0, 2'h2}, '{BC, 8'h20, 3'h0, 8'h0, 2'h2}, '{KS, 8'h20, 3'h0, 8'h0, 2'h2},
    '{KC, 8'h20, 3'h0, 8'h0, 2'h2}, '{KS, 8'h05, 3'h0, 8'h0, 2'h0}};

  always #2.5 clk = ~clk;

  t2io_core_model core (.o_op(op), .o_addr(addr), .o_bit(bitn), .o_wdata(wdata));
  t2io_regs dut (.i_ref_clk(clk), .i_resetn(rstn), .i_op(op), .i_addr(addr), .i_bit(bitn),
    .i_wdata(wdata), .o_ack(ack), .o_rdata(rdata), .o_skip(skip), .o_err(err),
    .i_count_step(step), .i_flag_set(fset), .o_ctrl_a(ca), .o_ctrl_b(cb), .o_count(cnt),
    .o_cmp_a(ma), .o_cmp_b(mb), .o_force_a(fa), .o_force_b(fb), .o_flags(flags));

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(negedge clk);
    chk(64'(all_out), 64'h0);
    rstn = 1'b1;
    @(negedge clk);
    chk(64'(all_out), 64'h0);
    fset = 3'h7;
    @(negedge clk);
    fset = 3'h0;
    $display("reset test done");
    // rows go back to back, each answer sampled before the next request
    core.raw = 1'b1;
    foreach (rows[i]) begin
      core.req(rows[i].op, rows[i].a, rows[i].b, rows[i].v);
      @(negedge clk);
      chk(64'({ack, err, skip, rdata}), 64'({1'b1, rows[i].se,
          (rows[i].op inside {IN, LD}) ? rows[i].v : 8'h0}));
    end
    chk(64'({ca, cb, ma, mb}), 64'({8'hf3, 8'h0f, 8'h5a, 8'ha5}));
    $display("table test done");
    core.raw = 1'b0;
    core.req(ST, 8'hb1, 3'h0, 8'hf5);
    @(negedge clk);
    chk(64'({fa, fb, cb}), 64'({2'b11, 8'h05}));
    core.req(ST, 8'hb2, 3'h0, 8'h80);
    step = 1'b1;
    @(negedge clk);
    chk(64'({fa, fb, cnt}), 64'({2'b00, 8'h80}));
    core.req(BS, 8'h17, 3'h0, 8'h0);
    fset = 3'h1;
    @(negedge clk);
    core.req(NOP, 8'h0, 3'h0, 8'h0);
    step = 1'b0;
    fset = 3'h0;
    chk(64'({cnt, flags}), 64'({8'h81, 8'h01}));
    $display("strobe test done");
    rstn = 1'b0;
    @(negedge clk);
    chk(64'(all_out), 64'h0);
    rstn = 1'b1;
    core.req(LD, 8'hb3, 3'h0, 8'h0);
    @(negedge clk);
    chk(64'({ack, rdata}), 64'({1'b1, 8'h0}));
    $display("second reset test done");
    test_done();
  end
endmodule : tb
